// ==== rtl/rwd_watchdog.sv ====
// Purpose: Binary countdown watchdog with two interrupt outputs plus a summary irq, AXI4-Lite slave
// Assumes: osc_clk is a free running 32.768 kHz oscillator pin, sampled here
// Notes: All logic runs on clock; oscillator edges become one-cycle enables
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps

// How it works
// - Count field bits 6..2 loads counter
// - Reads return live counter value
// - Step select picks 4s,1s,1/4s,1/16s
// - Period equals count times step
// - Writing zero count halts watchdog
// - Nonzero count write starts countdown
// - Rewrite mid-period restarts from new value
// - First period may differ one tick
// - Repeat mode: flag and auto reload
// - Single shot: flag, stay at zero
// - Flag sticks until software clears it
// - Per-output enable bits gate interrupts
// - Pulse form fires every period end
// - Level form follows the flag
// - Ticks divided from the crystal oscillator
module rwd_watchdog
   import rwd_pkg::*;
(
   // System
   input wire logic clock,
   input wire logic sys_rst,
   // Oscillator pin
   input wire logic osc_clk,
   // AXI4-Lite write
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Interrupts
   output logic irq_out_a,
   output logic irq_out_b,
   output logic irq
);
   import rwd_pkg::*;

   // Oscillator pin synchroniser and edge detect
   logic osc_s1_r, osc_s2_r, osc_s3_r;
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         osc_s1_r <= 1'b0;
         osc_s2_r <= 1'b0;
         osc_s3_r <= 1'b0;
      end else begin
         osc_s1_r <= osc_clk;
         osc_s2_r <= osc_s1_r;
         osc_s3_r <= osc_s2_r;
      end
   end
   wire osc_rise = osc_s2_r & ~osc_s3_r;

   // Divider chain from the oscillator; a tick is one clock wide
   logic [10:0] osc_div_r;
   logic [5:0] step_div_r;
   wire tick16 = osc_rise & (osc_div_r == OSC_PER_16HZ);
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         osc_div_r <= 11'h000;
         step_div_r <= 6'h00;
      end else begin
         if (osc_rise) osc_div_r <= osc_div_r + 11'h001;
         if (tick16) step_div_r <= step_div_r + 6'h01;
      end
   end
   // Divider never restarts on a load, so only the first period can be short
   wire tick4 = tick16 & (step_div_r[1:0] == DIV_Q);
   wire tick1 = tick16 & (step_div_r[3:0] == DIV_1S);
   wire tick_q = tick16 & (step_div_r == DIV_4S);

   // Registers
   logic mode_r;
   logic [1:0] step_r;
   logic [4:0] load_r, cnt_r, cnt_nxt;
   logic en_a_r, en_b_r, lvl_a_r, lvl_b_r;
   logic flag_r, exp_st_r;
   logic [1:0] mask_r;
   logic pulse_r;

   // Step tick selection
   logic step_tick;
   always_comb begin
      case (step_r)
         STEP_4S: step_tick = tick_q;
         STEP_1S: step_tick = tick1;
         STEP_Q: step_tick = tick4;
         STEP_16: step_tick = tick16;
         default: step_tick = tick_q;
      endcase
   end

   // AXI write channel: take address and data in either order
   logic aw_hold_r, w_hold_r, bvalid_r;
   logic [9:0] aw_addr_r;
   logic [7:0] w_data_r;
   logic w_lane_r;
   assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
   assign s_axi_wready = ~w_hold_r & ~bvalid_r;
   wire aw_fire = s_axi_awvalid & s_axi_awready;
   wire w_fire = s_axi_wvalid & s_axi_wready;
   wire aw_have = aw_hold_r | aw_fire;
   wire w_have = w_hold_r | w_fire;
   wire [9:0] wa = aw_hold_r ? aw_addr_r : s_axi_awaddr[9:0];
   wire [7:0] wd = w_hold_r ? w_data_r : s_axi_wdata[7:0];
   wire wl = w_hold_r ? w_lane_r : s_axi_wstrb[0];
   wire wr_go = aw_have & w_have & ~bvalid_r;
   wire wr_hit = (wa == ADDR_CTRL) | (wa == ADDR_EN_A) | (wa == ADDR_EN_B) |
      (wa == ADDR_STAT) | (wa == ADDR_MASK) | (wa == ADDR_FORM);
   wire wr_ok = wr_go & wl & (s_axi_awaddr[31:10] == 22'h0 | aw_hold_r);
   wire wr_ctrl = wr_ok & (wa == ADDR_CTRL);
   wire wr_stat = wr_ok & (wa == ADDR_STAT);
   wire [4:0] wr_cnt = wd[CNT_HI:CNT_LO];

   logic [1:0] bresp_r;
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OK;
         aw_addr_r <= 10'h000;
         w_data_r <= 8'h00;
         w_lane_r <= 1'b0;
      end else begin
         if (aw_fire) aw_addr_r <= s_axi_awaddr[9:0];
         if (w_fire) w_data_r <= s_axi_wdata[7:0];
         if (w_fire) w_lane_r <= s_axi_wstrb[0];
         aw_hold_r <= aw_have & ~wr_go;
         w_hold_r <= w_have & ~wr_go;
         if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? RESP_OK : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   // Countdown
   wire cnt_end = step_tick & (cnt_r == 5'h01);
   always_comb begin
      cnt_nxt = cnt_r;
      if (wr_ctrl) begin
         cnt_nxt = wr_cnt;
      end else if (step_tick & (cnt_r != CNT_ZERO)) begin
         if (cnt_end & mode_r) cnt_nxt = load_r;
         else cnt_nxt = cnt_r - 5'h01;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         mode_r <= 1'b0;
         step_r <= STEP_4S;
         load_r <= CNT_ZERO;
         cnt_r <= CNT_ZERO;
      end else begin
         cnt_r <= cnt_nxt;
         if (wr_ctrl) begin
            mode_r <= wd[BIT_MODE];
            step_r <= wd[STEP_HI:STEP_LO];
            load_r <= wr_cnt;
         end
      end
   end

   // Other software registers; flag clear is write one, set wins
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         en_a_r <= 1'b0;
         en_b_r <= 1'b0;
         lvl_a_r <= 1'b0;
         lvl_b_r <= 1'b0;
         mask_r <= 2'b00;
         flag_r <= 1'b0;
         exp_st_r <= 1'b0;
      end else begin
         if (wr_ok & (wa == ADDR_EN_A)) en_a_r <= wd[BIT_WD_EN];
         if (wr_ok & (wa == ADDR_EN_B)) en_b_r <= wd[BIT_WD_EN];
         if (wr_ok & (wa == ADDR_MASK)) mask_r <= wd[1:0];
         if (wr_ok & (wa == ADDR_FORM)) begin
            lvl_a_r <= wd[0];
            lvl_b_r <= wd[1];
         end
         if (cnt_end) flag_r <= 1'b1;
         else if (wr_stat & wd[ST_FLAG]) flag_r <= 1'b0;
         if (cnt_end) exp_st_r <= 1'b1;
         else if (wr_stat & wd[ST_EXP]) exp_st_r <= 1'b0;
      end
   end

   // Pulse lasts from period end until the next step tick
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) pulse_r <= 1'b0;
      else if (cnt_end) pulse_r <= 1'b1;
      else if (step_tick) pulse_r <= 1'b0;
   end

   // Interrupt outputs, registered
   // One clock low at each period end, so a one-step period still shows an edge per end
   wire pulse_out = pulse_r & ~cnt_end;
   wire irq_a_nxt = en_a_r & (lvl_a_r ? flag_r : pulse_out);
   wire irq_b_nxt = en_b_r & (lvl_b_r ? flag_r : pulse_out);
   logic irq_a_r, irq_b_r, irq_r;
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         irq_a_r <= 1'b0;
         irq_b_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         irq_a_r <= irq_a_nxt;
         irq_b_r <= irq_b_nxt;
         irq_r <= |({exp_st_r, flag_r} & mask_r);
      end
   end
   assign irq_out_a = irq_a_r;
   assign irq_out_b = irq_b_r;
   assign irq = irq_r;

   // AXI read channel
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   assign s_axi_arready = ~rvalid_r;
   wire ar_fire = s_axi_arvalid & ~rvalid_r;
   wire [9:0] ra = s_axi_araddr[9:0];
   wire hi_ok = s_axi_araddr[31:10] == 22'h0;
   wire [7:0] rd_ctrl = {mode_r, cnt_r, step_r};
   logic [7:0] rd_val;
   logic rd_hit;
   always_comb begin
      rd_hit = hi_ok;
      case (ra)
         ADDR_CTRL: rd_val = rd_ctrl;
         ADDR_EN_A: rd_val = {2'b00, en_a_r, 5'h00};
         ADDR_EN_B: rd_val = {2'b00, en_b_r, 5'h00};
         ADDR_STAT: rd_val = {6'h00, exp_st_r, flag_r};
         ADDR_MASK: rd_val = {6'h00, mask_r};
         ADDR_FORM: rd_val = {6'h00, lvl_b_r, lvl_a_r};
         default: begin
            rd_val = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= RESP_OK;
      end else if (ar_fire) begin
         rvalid_r <= 1'b1;
         rdata_r <= {24'h000000, rd_hit ? rd_val : 8'h00};
         rresp_r <= rd_hit ? RESP_OK : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // Checks
   property p_load;
      @(posedge clock) disable iff (sys_rst) wr_ctrl |=> cnt_r == $past(wr_cnt);
   endproperty
   a_load: assert property (p_load) else $error("count not loaded");

   property p_halt;
      @(posedge clock) disable iff (sys_rst)
         (cnt_r == CNT_ZERO && !wr_ctrl) |=> cnt_r == CNT_ZERO;
   endproperty
   a_halt: assert property (p_halt) else $error("halted counter moved");

   property p_repeat;
      @(posedge clock) disable iff (sys_rst)
         (cnt_end && mode_r && !wr_ctrl) |=> cnt_r == $past(load_r) && flag_r;
   endproperty
   a_repeat: assert property (p_repeat) else $error("no reload");

   property p_single;
      @(posedge clock) disable iff (sys_rst)
         (cnt_end && !mode_r && !wr_ctrl) |=> cnt_r == CNT_ZERO && flag_r;
   endproperty
   a_single: assert property (p_single) else $error("single shot wrong");

   property p_flag;
      @(posedge clock) disable iff (sys_rst)
         (flag_r && !(wr_stat && wd[ST_FLAG])) |=> flag_r;
   endproperty
   a_flag: assert property (p_flag) else $error("flag dropped");

   property p_level;
      @(posedge clock) disable iff (sys_rst)
         (en_b_r && lvl_b_r) |=> irq_out_b == $past(flag_r);
   endproperty
   a_level: assert property (p_level) else $error("level irq wrong");

   property p_pulse;
      @(posedge clock) disable iff (sys_rst)
         (cnt_end && en_a_r && !lvl_a_r && !(wr_ok && wa == ADDR_EN_A)) |=> ##1 irq_out_a;
   endproperty
   a_pulse: assert property (p_pulse) else $error("no pulse");

   property p_gap;
      @(posedge clock) disable iff (sys_rst)
         (cnt_end && en_a_r && !lvl_a_r) |=> !irq_out_a;
   endproperty
   a_gap: assert property (p_gap) else $error("no low clock at period end");

   property p_pulse_end;
      @(posedge clock) disable iff (sys_rst)
         (pulse_r && step_tick && !cnt_end) |=> !pulse_r;
   endproperty
   a_pulse_end: assert property (p_pulse_end) else $error("pulse too long");

   property p_enable;
      @(posedge clock) disable iff (sys_rst) !en_a_r |=> !irq_out_a;
   endproperty
   a_enable: assert property (p_enable) else $error("disabled irq fired");

   property p_step;
      @(posedge clock) disable iff (sys_rst)
         (cnt_r != CNT_ZERO && !step_tick && !wr_ctrl) |=> cnt_r == $past(cnt_r);
   endproperty
   a_step: assert property (p_step) else $error("count moved off tick");
endmodule // rwd_watchdog

// ==== rtl/rwd_pkg.sv ====
// Purpose: Constants for the countdown watchdog block
// Assumes: 50 MHz system clock, AXI4-Lite register access
// Notes: Offsets 0x2d, 0x29, 0x2a are not word multiples, so they are indices
package rwd_pkg;
   localparam int unsigned CLK_HZ = 50000000;
   localparam int unsigned OSC_HZ = 32768;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CTRL = 8'h2d;
   localparam logic [7:0] IDX_EN_A = 8'h29;
   localparam logic [7:0] IDX_EN_B = 8'h2a;
   localparam logic [7:0] IDX_STAT = 8'h30;
   localparam logic [7:0] IDX_MASK = 8'h31;
   localparam logic [7:0] IDX_FORM = 8'h32;
   localparam logic [9:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
   localparam logic [9:0] ADDR_EN_A = {IDX_EN_A, 2'b00};
   localparam logic [9:0] ADDR_EN_B = {IDX_EN_B, 2'b00};
   localparam logic [9:0] ADDR_STAT = {IDX_STAT, 2'b00};
   localparam logic [9:0] ADDR_MASK = {IDX_MASK, 2'b00};
   localparam logic [9:0] ADDR_FORM = {IDX_FORM, 2'b00};
   // Control register fields
   localparam int unsigned BIT_MODE = 7;
   localparam int unsigned CNT_HI = 6;
   localparam int unsigned CNT_LO = 2;
   localparam int unsigned STEP_HI = 1;
   localparam int unsigned STEP_LO = 0;
   localparam logic [7:0] CTRL_RST = 8'h00;
   // Enable bit inside the interrupt enable registers
   localparam int unsigned BIT_WD_EN = 5;
   localparam logic [4:0] CNT_ZERO = 5'h00;
   // Oscillator divider: 16 Hz base tick, then 4 Hz, 1 Hz, 0.25 Hz
   localparam int unsigned OSC_HALF = CLK_HZ / (2 * OSC_HZ);
   localparam logic [9:0] OSC_HALF_M1 = 10'(OSC_HALF - 1);
   localparam logic [10:0] OSC_PER_16HZ = 11'h7ff;
   localparam logic [5:0] DIV_4S = 6'h3f;
   localparam logic [3:0] DIV_1S = 4'hf;
   localparam logic [1:0] DIV_Q = 2'b11;
   localparam logic [1:0] STEP_4S = 2'b00;
   localparam logic [1:0] STEP_1S = 2'b01;
   localparam logic [1:0] STEP_Q = 2'b10;
   localparam logic [1:0] STEP_16 = 2'b11;
   // AXI responses
   localparam logic [1:0] RESP_OK = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Status bits
   localparam int unsigned ST_FLAG = 0;
   localparam int unsigned ST_EXP = 1;
endpackage

// ==== testbench/rwd_watchdog_tb_top.sv ====
// Purpose: Self-checking bench for the countdown watchdog over AXI4-Lite
// Assumes: osc_clk toggles every clock, so one 16 Hz step is 4096 clocks
// Notes: Only periods after the first are held to an exact figure
`timescale 1ns/10ps
module rwd_watchdog_tb_top;
   import rwd_pkg::*;
   localparam int TK = 4096;
   logic clock, sys_rst;
   logic osc_clk = 1'b0;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, irq_out_a, irq_out_b, irq;
   logic [31:0] rd;
   logic [9:0] regs [6];
   int failures, comparisons, cycles, n, t1;

   rwd_watchdog rwd_watchdog_inst (
      .clock(clock),
      .sys_rst(sys_rst),
      .osc_clk(osc_clk),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .irq_out_a(irq_out_a),
      .irq_out_b(irq_out_b),
      .irq(irq)
   );

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // Fastest oscillator the two-flop synchroniser can follow
   always @(posedge clock) osc_clk <= ~osc_clk;

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 95000) begin
         failures++;
         give_verdict();
      end
   end

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clock);
      s_axi_awaddr <= {22'h0, a};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rdr(input logic [9:0] a);
      @(posedge clock);
      s_axi_araddr <= {22'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // Waits until the chosen output shows lvl; n is lim when it never did
   task automatic wait_for(input int w, input logic lvl, input int lim);
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (n < lim && (w == 0 ? irq : (w == 1 ? irq_out_a : irq_out_b)) !== lvl);
   endtask

   initial begin
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_awvalid, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'h1;
      sys_rst = 1'b1;
      {failures, comparisons} = '0;
      regs = '{ADDR_CTRL, ADDR_EN_A, ADDR_EN_B, ADDR_STAT, ADDR_MASK, ADDR_FORM};
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      foreach (regs[i]) begin
         rdr(regs[i]);
         check("reset value", rd, 32'h0);
         check("read resp", {30'h0, rs}, {30'h0, RESP_OK});
      end
      rdr(10'h000);
      check("unmapped rresp", {30'h0, rs}, {30'h0, RESP_SLVERR});
      check("unmapped rdata", rd, 32'h0);
      wr(10'h3fc, 8'hff);
      check("unmapped bresp", {30'h0, rs}, {30'h0, RESP_SLVERR});
      // A write with lane 0 off must leave the register alone
      s_axi_wstrb <= 4'h0;
      wr(ADDR_MASK, 8'h03);
      s_axi_wstrb <= 4'h1;
      rdr(ADDR_MASK);
      check("lane 0 off, no store", rd, 32'h0);
      for (int s = 0; s < 4; s++) begin
         wr(ADDR_CTRL, {6'h0, 2'(s)});
         rdr(ADDR_CTRL);
         check("step field, halted", rd, 32'(s));
      end
      $display("test reset and fields done");
      // Count 5 replaced by 2 shortly after start
      wr(ADDR_MASK, 8'h01);
      wr(ADDR_CTRL, 8'h17);
      repeat (200) @(posedge clock);
      wr(ADDR_CTRL, 8'h0b);
      wait_for(0, 1'b1, 3 * TK);
      check("reload delay", 32'(n >= TK - 16 && n <= 2 * TK + 16), 32'h1);
      rdr(ADDR_CTRL);
      check("single shot count", rd, 32'h03);
      repeat (TK) @(posedge clock);
      rdr(ADDR_CTRL);
      check("single shot stays", rd, 32'h03);
      rdr(ADDR_STAT);
      check("flag sticky", {31'h0, rd[ST_FLAG]}, 32'h1);
      wr(ADDR_STAT, 8'h03);
      rdr(ADDR_STAT);
      check("flag cleared", {31'h0, rd[ST_FLAG]}, 32'h0);
      check("irq cleared", {31'h0, irq}, 32'h0);
      $display("test single shot done");
      // Zero written before the first step halts the count
      wr(ADDR_CTRL, 8'h0b);
      wr(ADDR_CTRL, 8'h03);
      wait_for(0, 1'b1, 2 * TK + 100);
      check("halted, no expiry", 32'(n), 32'(2 * TK + 100));
      rdr(ADDR_CTRL);
      check("halted count", rd, 32'h03);
      $display("test halt done");
      // Repeat mode: output A pulsed, output B level
      wr(ADDR_EN_A, 8'h20);
      wr(ADDR_EN_B, 8'h20);
      wr(ADDR_FORM, 8'h02);
      wr(ADDR_CTRL, 8'h8b);
      wait_for(1, 1'b1, 3 * TK);
      t1 = cycles;
      rdr(ADDR_CTRL);
      check("reloaded count", rd, 32'h8b);
      wait_for(1, 1'b0, TK + 8);
      check("pulse width", 32'(cycles - t1), 32'(TK));
      rdr(ADDR_CTRL);
      check("live count", rd, 32'h87);
      rdr(ADDR_CTRL);
      check("live count reread", rd, 32'h87);
      wait_for(1, 1'b1, 2 * TK);
      check("repeat period", 32'(cycles - t1), 32'(2 * TK));
      check("level output", {31'h0, irq_out_b}, 32'h1);
      check("summary irq", {31'h0, irq}, 32'h1);
      wr(ADDR_EN_A, 8'h00);
      wr(ADDR_STAT, 8'h03);
      repeat (4) @(posedge clock);
      check("level follows flag", {31'h0, irq_out_b}, 32'h0);
      wait_for(2, 1'b1, 2 * TK + 8);
      check("next period seen", 32'(n < 2 * TK + 8), 32'h1);
      check("disabled output", {31'h0, irq_out_a}, 32'h0);
      $display("test repeat done");
      // Quarter second step, count 1
      wr(ADDR_EN_A, 8'h20);
      wr(ADDR_CTRL, 8'h86);
      // With a one-step period output A stays high and drops for one clock at each end
      wait_for(1, 1'b0, 4 * TK + 8);
      wait_for(1, 1'b1, 4 * TK + 8);
      t1 = cycles;
      wait_for(1, 1'b0, 4 * TK + 8);
      check("pulse gap", 32'(cycles - t1), 32'(4 * TK - 1));
      wait_for(1, 1'b1, 4);
      check("quarter step period", 32'(cycles - t1), 32'(4 * TK));
      $display("test quarter step done");
      give_verdict();
   end
endmodule // rwd_watchdog_tb_top
